// ===== dpram_host_pkg.sv
// timing and layout constants for the dual-port sram host controller
// assumes a 25 MHz sys_clk; all pin timings expressed in ns then cycles
package dpram_host_pkg;
  localparam int ClkPeriodNs    = 40;
  localparam int AddrWidth      = 14;
  localparam int DataWidth      = 16;
  localparam int FlagAddrWidth  = 3;
  // minimum pin times, ns, slowest grade
  localparam int EnableToEndNs  = 45;
  localparam int AddrToEndNs    = 45;
  localparam int WritePulseNs   = 40;
  localparam int FloatNs        = 25;
  localparam int DataSetupNs    = 30;
  localparam int FlagWrToRdNs   = 5;
  localparam int ReadAccessNs   = 55;
  // derived cycle counts, least times round up
  function automatic int ceilCycles(input int ns);
    int c;
    c = (ns + ClkPeriodNs - 1) / ClkPeriodNs;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int EnableCycles   = ceilCycles(EnableToEndNs);
  localparam int AddrCycles     = ceilCycles(AddrToEndNs);
  localparam int PulseCycles    = ceilCycles(WritePulseNs);
  localparam int FloatSetCycles = ceilCycles(FloatNs + DataSetupNs);
  localparam int FlagGapCycles  = ceilCycles(FlagWrToRdNs);
  localparam int ReadCycles     = ceilCycles(ReadAccessNs);
  localparam int CntWidth       = 4;
  typedef enum logic [1:0] {
    CmdRamWrite,
    CmdRamRead,
    CmdFlagWrite,
    CmdFlagRead
  } cmd_e;
endpackage

// ===== pin_sync.sv
// three-stage synchroniser for the bidirectional data pins
// assumes sys_clk; first stage feeds only the second stage
`timescale 1ns/10ps
module pin_sync #(
  parameter int Width = 16
) (
  // clocking
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             clkEn,
  // data
  input  wire logic [Width-1:0] pinIn,
  output logic      [Width-1:0] syncOut
);
  logic [Width-1:0] s1Q;
  logic [Width-1:0] s2Q;
  logic [Width-1:0] s3Q;
  logic [Width-1:0] outQ;

  // a value counts once stages two and three agree
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1Q  <= '0;
      s2Q  <= '0;
      s3Q  <= '0;
      outQ <= '0;
    end else if (clkEn) begin
      s1Q <= pinIn;
      s2Q <= s1Q;
      s3Q <= s2Q;
      if (s2Q == s3Q) begin
        outQ <= s3Q;
      end
    end
  end

  assign syncOut = outQ;
endmodule

// ===== dpram_host.sv
// host-side controller driving one port of an asynchronous dual-port sram
// assumes one sys_clk domain; user issues a command with reqValid/reqReady
//
// Notes on behaviour
// - select ram or flag, hold through enable time
// - address changes only with strobe high
// - strobe pulse covers float plus data setup
// - address valid long enough before write end
// - enable asserted long enough before write end
// - data valid long enough, zero hold allowed
// - host meets data hold always
// - host never drives while device drives
// - wait after flag write before reading
// - chip enable high across flag sequence
`timescale 1ns/10ps
module dpram_host #(
  parameter int AddrW = dpram_host_pkg::AddrWidth,
  parameter int DataW = dpram_host_pkg::DataWidth
) (
  // clocking
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             clkEn,
  // user command
  input  wire logic             reqValid,
  output logic                  reqReady,
  input  wire logic [1:0]       reqCmd,
  input  wire logic [AddrW-1:0] reqAddr,
  input  wire logic [DataW-1:0] reqData,
  input  wire logic [1:0]       reqByteEn,
  // user answer
  output logic                  rspValid,
  output logic [DataW-1:0]      rspData,
  // sram control pins, active low
  output logic                  chip_enable_n,
  output logic                  flag_select_n,
  output logic                  rw_n,
  output logic                  output_enable_n,
  output logic                  upper_byte_enable_n,
  output logic                  lower_byte_enable_n,
  output logic [AddrW-1:0]      addr,
  // sram data pins
  input  wire logic [DataW-1:0] dataIn,
  output logic [DataW-1:0]      dataOut,
  output logic                  dataOe
);
  typedef enum logic [2:0] {
    Idle, Setup, Strobe, Recover, ReadWait, FlagGap
  } state_e;
  localparam int CW = dpram_host_pkg::CntWidth;
  localparam logic [CW-1:0] PulseCnt = CW'(dpram_host_pkg::PulseCycles);
  localparam logic [CW-1:0] ReadCnt  = CW'(dpram_host_pkg::ReadCycles + 3);
  localparam logic [CW-1:0] GapCnt   = CW'(dpram_host_pkg::FlagGapCycles);

  state_e stateQ, stateD;
  logic [CW-1:0] cntQ, cntD;
  logic          isFlagQ, isWriteQ;
  logic          ceQ, selFlagQ, rwQ, oeQ, upperQ, lowerQ, drvQ, rdyQ, rvQ;
  logic [1:0]    reqByteEnQ;
  logic [AddrW-1:0] addrQ;
  logic [DataW-1:0] doQ, rdQ;
  logic [DataW-1:0] syncData;
  logic          take, cmdFlag, cmdWrite, cntDone;

  pin_sync #(.Width(DataW)) uSync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .clkEn   (clkEn),
    .pinIn   (dataIn),
    .syncOut (syncData)
  );

  // command decode
  assign take     = reqValid && rdyQ;
  assign cmdFlag  = reqCmd[1];
  assign cmdWrite = !reqCmd[0];
  assign cntDone  = (cntQ == '0);

  // sequencer: setup, strobe, recover for writes; strobe then wait for reads
  always_comb begin
    stateD = stateQ;
    cntD   = cntDone ? cntQ : cntQ - CW'(1);
    unique case (stateQ)
      Idle:     if (take) stateD = Setup;
      Setup: begin
        stateD = Strobe;
        cntD   = isWriteQ ? PulseCnt : ReadCnt;
      end
      Strobe:   if (cntDone) begin
        stateD = isWriteQ ? Recover : ReadWait;
      end
      Recover: begin
        stateD = isFlagQ ? FlagGap : Idle;
        cntD   = GapCnt;
      end
      ReadWait: stateD = Idle;
      FlagGap:  if (cntDone) stateD = Idle;
      default:  stateD = Idle; // two spare codes, fall back to idle
    endcase
  end

  // pin registers: every pin output comes from a flop
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stateQ <= Idle;
      cntQ   <= '0;
      {isFlagQ, isWriteQ} <= 2'h0;
      {ceQ, selFlagQ, rwQ, oeQ, upperQ, lowerQ} <= 6'h3F;
      {drvQ, rdyQ, rvQ} <= 3'h2;
      addrQ  <= '0;
      doQ    <= '0;
      rdQ    <= '0;
    end else if (clkEn) begin
      stateQ <= stateD;
      cntQ   <= cntD;
      rvQ    <= 1'b0;
      if (take) begin
        // address moves only while all controls are high
        isFlagQ  <= cmdFlag;
        isWriteQ <= cmdWrite;
        addrQ    <= reqAddr;
        doQ      <= reqData;
        rdyQ     <= 1'b0;
        oeQ      <= 1'b1; // output enable high so short pulse is legal
      end
      if (stateQ == Setup) begin
        // exactly one of ram or flag selected; flag keeps ce high
        ceQ      <= isFlagQ;
        selFlagQ <= !isFlagQ;
        // ram lanes from byte enables; flag access keeps both low
        upperQ   <= isFlagQ ? 1'b0 : !reqByteEnQ[1];
        lowerQ   <= isFlagQ ? 1'b0 : !reqByteEnQ[0];
        rwQ  <= !isWriteQ; // enable and strobe fall together
        oeQ  <= isWriteQ;
        drvQ <= isWriteQ;  // data valid for the whole pulse
      end
      if ((stateQ == Strobe) && cntDone) begin
        // enable and strobe rise together ending the write
        {ceQ, selFlagQ, rwQ, oeQ, upperQ, lowerQ} <= 6'h3F;
        drvQ <= 1'b0;  // released at write end, zero hold after the strobe rises
        if (!isWriteQ) begin
          // flag read: every bit carries the flag, take bit 0
          rdQ <= isFlagQ ? {DataW{syncData[0]}} : syncData;
          rvQ <= 1'b1;
        end
      end
      if ((stateD == Idle) && (stateQ != Idle)) begin
        rdyQ <= 1'b1; // flag read waits out the write gap
      end
    end
  end

  // byte enables captured with the command
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reqByteEnQ <= 2'h0;
    end else if (clkEn && take) begin
      reqByteEnQ <= reqByteEn;
    end
  end

  // outputs straight from flops
  assign reqReady            = rdyQ;
  assign rspValid            = rvQ;
  assign rspData             = rdQ;
  assign chip_enable_n       = ceQ;
  assign flag_select_n       = selFlagQ;
  assign rw_n                = rwQ;
  assign output_enable_n     = oeQ;
  assign upper_byte_enable_n = upperQ;
  assign lower_byte_enable_n = lowerQ;
  assign addr                = addrQ;
  assign dataOut             = doQ;
  assign dataOe              = drvQ;

  // assertions
  // setup only counts as consumed when the enable let it advance
  sequence writeStart_s;
    (stateQ == Setup) && isWriteQ && clkEn;
  endsequence

  selSingle_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(!chip_enable_n && !flag_select_n)) else $error("ram and flag selected together");
  addrStable_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!rw_n || !chip_enable_n) |=> $stable(addr) || rw_n) else $error("address moved in strobe");
  pulseLen_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(rw_n) |-> !rw_n [*2]) else $error("write pulse too short");
  selHold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    writeStart_s |=> (!chip_enable_n || !flag_select_n)) else $error("no select");
  dataDrive_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !rw_n |-> dataOe) else $error("data not driven in write");
  busFree_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    dataOe |-> output_enable_n) else $error("drive against device");
  flagCe_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !flag_select_n |-> chip_enable_n) else $error("ce low in flag access");
  releaseEnd_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(rw_n) && clkEn |-> !dataOe) else $error("bus held after write");
endmodule

// ===== sram_port_model.sv
// behavioural model of one sram port: word array plus eight flags
// assumes the host pins of dpram_host; lone port, so flags never contend
`timescale 1ns/10ps
module sram_port_model (
  // control pins, active low
  input  wire logic        chip_enable_n,
  input  wire logic        flag_select_n,
  input  wire logic        rw_n,
  input  wire logic        output_enable_n,
  input  wire logic        upper_byte_enable_n,
  input  wire logic        lower_byte_enable_n,
  input  wire logic [13:0] addr,
  // data pins
  input  wire logic [15:0] dataIn,
  output logic      [15:0] devData,
  output logic             devDrive
);
  logic [15:0] mem [16384];
  logic [7:0]  flags = 8'hFF;
  logic [15:0] dSkew;
  logic [13:0] aSkew;
  logic [1:0]  beSkew;
  wire ramWr  = !chip_enable_n && flag_select_n && !rw_n;
  wire flagWr = chip_enable_n && !flag_select_n && !rw_n;
  wire ramRd  = !chip_enable_n && flag_select_n && rw_n && !output_enable_n;
  wire flagRd = chip_enable_n && !flag_select_n && rw_n && !output_enable_n;
  // input skew so the closing edge still sees held address, lanes, data
  assign #1 dSkew  = dataIn;
  assign #1 aSkew  = addr;
  assign #1 beSkew = {upper_byte_enable_n, lower_byte_enable_n};
  // drivers off while strobe low, on only in a read with output enable low
  assign devDrive = ramRd || flagRd;
  assign devData  = flagRd ? {16{flags[addr[2:0]]}} : mem[addr];
  // array takes the overlap's data at its end, enabled lanes only
  always @(negedge ramWr) begin
    if (!beSkew[0]) mem[aSkew][7:0] = dSkew[7:0];
    if (!beSkew[1]) mem[aSkew][15:8] = dSkew[15:8];
  end
  // zero takes the free token, one frees it; a lone port never lands in the
  // contention window, so the grant always goes to this port
  always @(negedge flagWr) flags[aSkew[2:0]] = dSkew[0];
endmodule

// ===== dual_port_sram_write_and_flag_access_tb_top.sv
// random and corner tests of dpram_host against the sram port model
// assumes the host package and sram_port_model are compiled first
`timescale 1ns/10ps
module dual_port_sram_write_and_flag_access_tb_top;
  logic        sys_clk = 1'b0, rst_n = 1'b0, reqValid = 1'b0, clkEn = 1'b1;
  logic        reqReady, rspValid, dataOe, devDrive, chip_enable_n, flag_select_n;
  logic        rw_n, output_enable_n, upper_byte_enable_n, lower_byte_enable_n;
  logic [1:0]  reqCmd = 2'h0, reqByteEn = 2'h0, be;
  logic [13:0] reqAddr = 14'h0000, addr, lastAddr, a;
  logic [15:0] reqData = 16'h0000, rspData, dataOut, devData, bus, d0, d1, q;
  logic [15:0] lastBus = 16'h0000;
  int          comparisons = 0, nFail = 0, cycles = 0, wCnt = 0;
  wire  [7:0]  pins = {chip_enable_n, flag_select_n, rw_n, output_enable_n,
                       upper_byte_enable_n, lower_byte_enable_n, reqReady, dataOe};

  dpram_host dut_u (
    .sys_clk             (sys_clk),
    .rst_n               (rst_n),
    .clkEn               (clkEn),
    .reqValid            (reqValid),
    .reqReady            (reqReady),
    .reqCmd              (reqCmd),
    .reqAddr             (reqAddr),
    .reqData             (reqData),
    .reqByteEn           (reqByteEn),
    .rspValid            (rspValid),
    .rspData             (rspData),
    .chip_enable_n       (chip_enable_n),
    .flag_select_n       (flag_select_n),
    .rw_n                (rw_n),
    .output_enable_n     (output_enable_n),
    .upper_byte_enable_n (upper_byte_enable_n),
    .lower_byte_enable_n (lower_byte_enable_n),
    .addr                (addr),
    .dataIn              (bus),
    .dataOut             (dataOut),
    .dataOe              (dataOe)
  );
  sram_port_model sram_u (
    .chip_enable_n       (chip_enable_n),
    .flag_select_n       (flag_select_n),
    .rw_n                (rw_n),
    .output_enable_n     (output_enable_n),
    .upper_byte_enable_n (upper_byte_enable_n),
    .lower_byte_enable_n (lower_byte_enable_n),
    .addr                (addr),
    .dataIn              (bus),
    .devData             (devData),
    .devDrive            (devDrive)
  );

  // released bus shows a changing pattern, never a stale value
  assign bus = devDrive ? devData : (dataOe ? dataOut : ~lastBus);

  // 25 MHz clock
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      nFail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic finishTest;
    $display("comparisons %0d mismatches %0d", comparisons, nFail);
    if (nFail == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  function automatic logic [15:0] laneMerge(input logic [15:0] o, n, input logic [1:0] en);
    return {en[1] ? n[15:8] : o[15:8], en[0] ? n[7:0] : o[7:0]};
  endfunction

  // one request taken at an edge with reqReady high; reads wait for the answer
  task automatic req(input logic [1:0] c, input logic [13:0] ad, input logic [15:0] dt,
                     input logic [1:0] en, output logic [15:0] r);
    int n;
    n = 0;
    while (reqReady !== 1'b1 && n < 50) begin
      @(posedge sys_clk);
      #1 n++;
    end
    {reqValid, reqCmd, reqAddr, reqData, reqByteEn} = {1'b1, c, ad, dt, en};
    @(posedge sys_clk);
    #1 reqValid = 1'b0;
    while (c[0] && rspValid !== 1'b1 && n < 150) begin
      @(posedge sys_clk);
      #1 n++;
    end
    r = (n < 150) ? rspData : 16'hXXXX;
  endtask

  // pin watch on falling edges, where everything has settled
  always @(negedge sys_clk) begin
    lastBus <= bus;
    lastAddr <= addr;
    cycles <= cycles + 1;
    if (rst_n) begin
      chk("bus owners", 16'h0000, {15'h0000, devDrive & dataOe});
      chk("one select", 16'h0001, {15'h0000, chip_enable_n | flag_select_n});
      if (addr !== lastAddr) begin
        chk("addr move", 16'h0001, {15'h0000, rw_n | chip_enable_n});
      end
      if (!rw_n) begin
        wCnt <= wCnt + 1;
        chk("write drive", 16'h0003, {14'h0000, dataOe, output_enable_n});
      end else if (wCnt != 0) begin
        wCnt <= 0;
        chk("pulse long", 16'h0001, {15'h0000, wCnt >= dpram_host_pkg::EnableCycles});
      end
    end
    // hang guard: a full run needs well under a thousand cycles
    if (cycles > 6000) begin
      nFail++;
      finishTest();
    end
  end

  initial begin
    void'($urandom(32'h2a12));
    repeat (4) @(posedge sys_clk);
    #1 chk("reset pins", 16'h00FE, {8'h00, pins});
    rst_n = 1'b1;
    for (int i = 0; i < 8; i++) begin
      a = (i == 0) ? 14'h0000 : (i == 1) ? 14'h3FFF : 14'($urandom);
      d0 = 16'($urandom);
      d1 = 16'($urandom);
      be = 2'(i);
      req(dpram_host_pkg::CmdRamWrite, a, d0, 2'h3, q);
      req(dpram_host_pkg::CmdRamWrite, a, d1, be, q);
      req(dpram_host_pkg::CmdRamRead, a, 16'h0000, 2'h3, q);
      chk("ram word", laneMerge(d0, d1, be), q);
    end
    $display("test ram lanes done");
    // enable dropped mid-write: control pins, reqReady and dataOe must stand until it returns
    d0 = 16'($urandom);
    req(dpram_host_pkg::CmdRamWrite, 14'h0155, d0, 2'h3, q);
    @(posedge sys_clk);
    #1 chk("write pins", 16'h0051, {8'h00, pins});
    clkEn = 1'b0;
    repeat (5) @(posedge sys_clk);
    #1 chk("frozen pins", 16'h0051, {8'h00, pins});
    clkEn = 1'b1;
    req(dpram_host_pkg::CmdRamRead, 14'h0155, 16'h0000, 2'h3, q);
    chk("frozen word", d0, q);
    $display("test freeze done");
    for (int f = 0; f < 8; f++) begin
      req(dpram_host_pkg::CmdFlagWrite, 14'(f), {15'($urandom), 1'b0}, 2'h3, q);
      req(dpram_host_pkg::CmdFlagRead, 14'(f), 16'h0000, 2'h3, q);
      chk("flag taken", 16'h0000, q);
      req(dpram_host_pkg::CmdFlagWrite, 14'(f), {15'($urandom), 1'b1}, 2'h3, q);
      req(dpram_host_pkg::CmdFlagRead, 14'(f), 16'h0000, 2'h3, q);
      chk("flag freed", 16'hFFFF, q);
    end
    $display("test flags done");
    finishTest();
  end
endmodule
